// >>> design/idm_pkg.sv
// shared constants, types and helpers for the internal data memory map
package idm_pkg;

  // ==========================================================
  // address map
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] BIT_SEG_BASE = 8'h20;
  localparam logic [7:0] SP_ADDR = 8'h81;
  localparam logic [7:0] PSW_ADDR = 8'hd0;
  localparam int SFR_BYTES = 128;
  localparam int XDATA_BYTES = 65536;
  localparam int CODE_BYTES = 65536;

  // ==========================================================
  // reset values and field positions
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [1:0] BANK_RESET = 2'h0;
  localparam int PSW_BANK_LSB = 3;
  localparam int PSW_BANK_MSB = 4;
  localparam logic [7:0] STEP_ONE = 8'h01;

  // ==========================================================
  // core operations
  typedef enum logic [3:0] {
    OP_NONE,
    OP_DIR_RD,
    OP_DIR_WR,
    OP_IND_RD,
    OP_IND_WR,
    OP_REG_RD,
    OP_REG_WR,
    OP_BIT_RD,
    OP_BIT_WR,
    OP_PUSH,
    OP_POP,
    OP_XDATA_RD,
    OP_XDATA_WR,
    OP_CODE_RD,
    OP_IRET
  } idm_op_e;

  typedef struct packed {
    logic done;
    logic [7:0] rdata;
    logic rbit;
    logic xreq;
    logic xwe;
    logic [15:0] xaddr;
    logic [7:0] xwdata;
    logic cint;
    logic cext;
    logic [15:0] caddr;
    logic [1:0] inprog;
    logic [1:0] bank;
    logic [7:0] sp;
  } idm_top_s;

  // ==========================================================
  // helpers
  // byte holding a bit: segment 20h-2fh below 80h, else an sfr byte
  function automatic logic [7:0] idm_bit_byte(input logic [7:0] bit_addr);
    if (bit_addr[7])
      return {bit_addr[7:3], 3'h0};
    else
      return BIT_SEG_BASE + {4'h0, bit_addr[6:3]};
  endfunction

  // working register n of bank b sits at 8*b+n
  function automatic logic [7:0] idm_reg_addr(input logic [1:0] bank,
                                              input logic [2:0] num);
    return {3'h0, bank, num};
  endfunction

endpackage

// >>> design/idm_port_if.sv
// byte port between the map controller and its storage blocks
`timescale 1ns/1ps
`default_nettype none
interface idm_port_if;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic sp_up;
  logic sp_down;
  logic [7:0] sp;
  logic [1:0] bank;
  modport ctl(output we, addr, wdata, sp_up, sp_down,
              input rdata, sp, bank);
  modport ram(input we, addr, wdata, output rdata);
  modport sfr(input we, addr, wdata, sp_up, sp_down,
              output rdata, sp, bank);
endinterface
`default_nettype wire

// >>> design/idm_ram.sv
// on-chip data ram, lower 128 bytes plus optional upper 128 bytes
`timescale 1ns/1ps
`default_nettype none
module idm_ram
  import idm_pkg::*;
#(
  parameter int BYTES = 256
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // byte port
  idm_port_if.ram port
);

  localparam int AW = $clog2(BYTES);

  typedef struct packed {
    logic [BYTES-1:0][7:0] mem;
  } idm_ram_s;

  idm_ram_s state_ff;
  idm_ram_s nxt_state;
  logic in_range;

  if (!(BYTES == 128 || BYTES == 256))
    $error("idm_ram: BYTES must be 128 or 256");

  assign in_range = {1'b0, port.addr} < 9'(BYTES);
  // missing upper ram reads zero and drops writes
  assign port.rdata = in_range ? state_ff.mem[port.addr[AW-1:0]] : 8'h00;

  always_comb
  begin
    nxt_state = state_ff;
    if (port.we && in_range)
      nxt_state.mem[port.addr[AW-1:0]] = port.wdata;
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

endmodule
`default_nettype wire

// >>> design/idm_sfr.sv
// special function register space at 80h-ffh, direct access only
`timescale 1ns/1ps
`default_nettype none
module idm_sfr
  import idm_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // byte port with stack pointer steps
  idm_port_if.sfr port
);

  localparam logic [6:0] SP_IDX = SP_ADDR[6:0];
  localparam logic [6:0] PSW_IDX = PSW_ADDR[6:0];

  typedef struct packed {
    logic [SFR_BYTES-1:0][7:0] mem;
  } idm_sfr_s;

  idm_sfr_s state_ff;
  idm_sfr_s nxt_state;

  assign port.rdata = port.addr[7] ? state_ff.mem[port.addr[6:0]] : 8'h00;
  assign port.sp = state_ff.mem[SP_IDX];
  assign port.bank =
    state_ff.mem[PSW_IDX][PSW_BANK_MSB:PSW_BANK_LSB];

  always_comb
  begin
    nxt_state = state_ff;
    if (port.sp_up)
      nxt_state.mem[SP_IDX] = state_ff.mem[SP_IDX] + STEP_ONE;
    else if (port.sp_down)
      nxt_state.mem[SP_IDX] = state_ff.mem[SP_IDX] - STEP_ONE;
    else if (port.we && port.addr[7])
      nxt_state.mem[port.addr[6:0]] = port.wdata;
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_ff <= '0;
      state_ff.mem[SP_IDX] <= SP_RESET;
    end
    else
      state_ff <= nxt_state;
  end

endmodule
`default_nettype wire

// >>> design/idm_data_map.sv
// internal data memory map: address decode of all core memory accesses
`timescale 1ns/1ps
`default_nettype none

module idm_data_map
  import idm_pkg::*;
#(
  parameter int RAM_BYTES = 256,
  parameter int CODE_ONCHIP = 8192
)
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  // core request
  input wire logic REQ_IN,
  input wire logic [3:0] OP_IN,
  input wire logic [15:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WBIT_IN,
  // interrupt acknowledge
  input wire logic IRQ_ACK_IN,
  input wire logic IRQ_LEVEL_IN,
  // answer
  output logic DONE_OUT,
  output logic [7:0] RDATA_OUT,
  output logic RBIT_OUT,
  // external data request
  output logic XDATA_REQ_OUT,
  output logic XDATA_WE_OUT,
  output logic [15:0] XDATA_ADDR_OUT,
  output logic [7:0] XDATA_WDATA_OUT,
  // program fetch routing
  output logic CODE_INT_OUT,
  output logic CODE_EXT_OUT,
  output logic [15:0] CODE_ADDR_OUT,
  // status
  output logic [1:0] INPROG_OUT,
  output logic [1:0] BANK_OUT,
  output logic [7:0] SP_OUT
);

  if (!(RAM_BYTES == 128 || RAM_BYTES == 256))
    $error("idm_data_map: RAM_BYTES must be 128 or 256");
  if (!(CODE_ONCHIP == 4096 || CODE_ONCHIP == 8192))
    $error("idm_data_map: CODE_ONCHIP must be 4096 or 8192");

  idm_top_s state_ff;
  idm_top_s nxt_state;
  idm_op_e op;
  logic [7:0] bit_byte;
  logic [7:0] bit_src;
  logic code_low;

  idm_port_if ram_if();
  idm_port_if sfr_if();

  // ==========================================================
  // storage
  idm_ram #(.BYTES(RAM_BYTES)) u_ram (
    .clk_in(CLK_IN),
    .resetn_in(RESETN_IN),
    .port(ram_if.ram)
  );

  idm_sfr u_sfr (
    .clk_in(CLK_IN),
    .resetn_in(RESETN_IN),
    .port(sfr_if.sfr)
  );

  // ==========================================================
  // decode
  always_comb
  begin
    op = idm_op_e'(OP_IN);
    bit_byte = idm_bit_byte(ADDR_IN[7:0]);
    code_low = {1'b0, ADDR_IN} < 17'(CODE_ONCHIP);
    nxt_state = state_ff;
    nxt_state.done = REQ_IN && (op != OP_NONE);
    nxt_state.xreq = 1'b0;
    nxt_state.xwe = 1'b0;
    nxt_state.cint = 1'b0;
    nxt_state.cext = 1'b0;
    ram_if.we = 1'b0;
    ram_if.addr = ADDR_IN[7:0];
    ram_if.wdata = WDATA_IN;
    ram_if.sp_up = 1'b0;
    ram_if.sp_down = 1'b0;
    sfr_if.we = 1'b0;
    sfr_if.addr = ADDR_IN[7:0];
    sfr_if.wdata = WDATA_IN;
    sfr_if.sp_up = 1'b0;
    sfr_if.sp_down = 1'b0;
    bit_src = 8'h00;
    if (REQ_IN)
    begin
      case (op)
        OP_DIR_RD:
        begin
          // direct: upper half is sfr, lower half is ram
          if (ADDR_IN[7])
            nxt_state.rdata = sfr_if.rdata;
          else
            nxt_state.rdata = ram_if.rdata;
        end
        OP_DIR_WR:
        begin
          sfr_if.we = ADDR_IN[7];
          ram_if.we = !ADDR_IN[7];
        end
        OP_IND_RD:
          nxt_state.rdata = ram_if.rdata;
        OP_IND_WR:
          ram_if.we = 1'b1;
        OP_REG_RD:
        begin
          ram_if.addr = idm_reg_addr(sfr_if.bank, ADDR_IN[2:0]);
          nxt_state.rdata = ram_if.rdata;
        end
        OP_REG_WR:
        begin
          ram_if.addr = idm_reg_addr(sfr_if.bank, ADDR_IN[2:0]);
          ram_if.we = 1'b1;
        end
        OP_BIT_RD, OP_BIT_WR:
        begin
          // bits below 80h live in ram bytes 20h-2fh
          ram_if.addr = bit_byte;
          sfr_if.addr = bit_byte;
          bit_src = ADDR_IN[7] ? sfr_if.rdata : ram_if.rdata;
          nxt_state.rbit = bit_src[ADDR_IN[2:0]];
          if (op == OP_BIT_WR)
          begin
            ram_if.wdata = bit_src;
            ram_if.wdata[ADDR_IN[2:0]] = WBIT_IN;
            sfr_if.wdata = ram_if.wdata;
            ram_if.we = !ADDR_IN[7];
            sfr_if.we = ADDR_IN[7];
          end
        end
        OP_PUSH:
        begin
          // pre-increment then write through the indirect path
          ram_if.addr = sfr_if.sp + STEP_ONE;
          ram_if.we = 1'b1;
          sfr_if.sp_up = 1'b1;
        end
        OP_POP:
        begin
          ram_if.addr = sfr_if.sp;
          nxt_state.rdata = ram_if.rdata;
          sfr_if.sp_down = 1'b1;
        end
        OP_XDATA_RD, OP_XDATA_WR:
        begin
          nxt_state.xreq = 1'b1;
          nxt_state.xwe = (op == OP_XDATA_WR);
          nxt_state.xaddr = ADDR_IN;
          nxt_state.xwdata = WDATA_IN;
        end
        OP_CODE_RD:
        begin
          // code space never touches data storage
          nxt_state.cint = code_low;
          nxt_state.cext = !code_low;
          nxt_state.caddr = ADDR_IN;
        end
        OP_IRET:
        begin
          // the highest level in service ends first
          if (state_ff.inprog[1])
            nxt_state.inprog[1] = 1'b0;
          else
            nxt_state.inprog[0] = 1'b0;
        end
        default:
          nxt_state.done = 1'b0;
      endcase
    end
    // an acknowledge in the same cycle as a return wins
    if (IRQ_ACK_IN)
      nxt_state.inprog[IRQ_LEVEL_IN] = 1'b1;
    nxt_state.sp = sfr_if.sp;
    nxt_state.bank = sfr_if.bank;
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      state_ff <= '0;
      state_ff.sp <= SP_RESET;
      state_ff.bank <= BANK_RESET;
    end
    else
      state_ff <= nxt_state;
  end

  // ==========================================================
  // outputs
  assign DONE_OUT = state_ff.done;
  assign RDATA_OUT = state_ff.rdata;
  assign RBIT_OUT = state_ff.rbit;
  assign XDATA_REQ_OUT = state_ff.xreq;
  assign XDATA_WE_OUT = state_ff.xwe;
  assign XDATA_ADDR_OUT = state_ff.xaddr;
  assign XDATA_WDATA_OUT = state_ff.xwdata;
  assign CODE_INT_OUT = state_ff.cint;
  assign CODE_EXT_OUT = state_ff.cext;
  assign CODE_ADDR_OUT = state_ff.caddr;
  assign INPROG_OUT = state_ff.inprog;
  assign BANK_OUT = state_ff.bank;
  assign SP_OUT = state_ff.sp;

  // ==========================================================
  // checks
  AST_PUSH_STEP: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    (REQ_IN && op == OP_PUSH) |=>
      sfr_if.sp == $past(sfr_if.sp) + STEP_ONE)
    else $error("push did not raise the stack pointer by one");

  AST_POP_STEP: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    (REQ_IN && op == OP_POP) |=>
      sfr_if.sp == $past(sfr_if.sp) - STEP_ONE ##1
      SP_OUT == $past(sfr_if.sp))
    else $error("pop did not lower the stack pointer by one");

  AST_PUSH_DATA: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    (REQ_IN && op == OP_PUSH) ##1 (REQ_IN && op == OP_POP) |=>
      RDATA_OUT == $past(WDATA_IN, 2))
    else $error("popped byte differs from pushed byte");

  AST_DIR_UPPER: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    (REQ_IN && op == OP_DIR_WR && ADDR_IN[7]) |->
      sfr_if.we && !ram_if.we)
    else $error("direct upper write did not go to the sfr space");

  AST_IND_UPPER: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    (REQ_IN && op == OP_IND_WR) |-> !sfr_if.we && !sfr_if.sp_up)
    else $error("indirect write reached the sfr space");

  AST_XDATA_ONLY: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    XDATA_REQ_OUT |->
      $past(REQ_IN) && ($past(op) inside {OP_XDATA_RD, OP_XDATA_WR}))
    else $error("external data request without an external move");

  AST_BANK_MAP: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    (REQ_IN && op inside {OP_REG_RD, OP_REG_WR}) |->
      ram_if.addr == {3'h0, sfr_if.bank, ADDR_IN[2:0]})
    else $error("working register mapped to the wrong address");

  AST_BIT_MAP: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    (REQ_IN && op == OP_BIT_RD && !ADDR_IN[7]) |=>
      RBIT_OUT == $past(ram_if.rdata[ADDR_IN[2:0]]) &&
      $past(ram_if.addr) == BIT_SEG_BASE + {4'h0, $past(ADDR_IN[6:3])})
    else $error("bit address mapped to the wrong byte or bit");

  AST_IRET_CLEAR: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    (REQ_IN && op == OP_IRET && INPROG_OUT[1] && !IRQ_ACK_IN) |=>
      !INPROG_OUT[1] && INPROG_OUT[0] == $past(INPROG_OUT[0]))
    else $error("interrupt return did not clear the level in service");

  AST_CODE_SPLIT: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    (REQ_IN && op == OP_CODE_RD) |=>
      CODE_INT_OUT == ({1'b0, CODE_ADDR_OUT} < 17'(CODE_ONCHIP)) &&
      CODE_EXT_OUT == !CODE_INT_OUT && !XDATA_REQ_OUT)
    else $error("program fetch routed to the wrong store");

endmodule
`default_nettype wire

// >>> tb/idm_core_model.sv
// behavioural core: issues memory operations and interrupt acknowledges
`timescale 1ns/1ps
`default_nettype none
module idm_core_model
  import idm_pkg::*;
(
  // clock and answer
  input wire logic clk_in,
  input wire logic done_in,
  // request
  output logic req_out,
  output logic [3:0] op_out,
  output logic [15:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wbit_out,
  // interrupt acknowledge
  output logic irq_ack_out,
  output logic irq_level_out
);
  initial
  begin
    req_out = 1'b0;
    op_out = OP_NONE;
    addr_out = 16'h0000;
    wdata_out = 8'h00;
    wbit_out = 1'b0;
    irq_ack_out = 1'b0;
    irq_level_out = 1'b0;
  end

  // ==========================================================
  // one operation; answer is due on the edge that takes it
  task automatic issue(input idm_op_e op, input logic [15:0] addr,
                       input logic [7:0] wdata, input logic wbit,
                       output logic done_seen);
    @(posedge clk_in);
    req_out <= 1'b1;
    op_out <= op;
    addr_out <= addr;
    wdata_out <= wdata;
    wbit_out <= wbit;
    @(posedge clk_in);
    // released lines show garbage, not the last value
    req_out <= 1'b0;
    op_out <= OP_NONE;
    addr_out <= ~addr;
    wdata_out <= ~wdata;
    wbit_out <= ~wbit;
    #1;
    done_seen = done_in;
  endtask

  // ==========================================================
  // two operations taken on consecutive edges
  task automatic issue_pair(input idm_op_e op_a, input logic [15:0] addr_a,
                            input logic [7:0] wdata_a,
                            input idm_op_e op_b, input logic [15:0] addr_b,
                            input logic [7:0] wdata_b);
    @(posedge clk_in);
    req_out <= 1'b1;
    op_out <= op_a;
    addr_out <= addr_a;
    wdata_out <= wdata_a;
    @(posedge clk_in);
    op_out <= op_b;
    addr_out <= addr_b;
    wdata_out <= wdata_b;
    @(posedge clk_in);
    req_out <= 1'b0;
    op_out <= OP_NONE;
    addr_out <= ~addr_b;
    wdata_out <= ~wdata_b;
    #1;
  endtask

  // ==========================================================
  // one-cycle acknowledge pulse for a priority level
  task automatic ack(input logic level);
    @(posedge clk_in);
    irq_ack_out <= 1'b1;
    irq_level_out <= level;
    @(posedge clk_in);
    irq_ack_out <= 1'b0;
    irq_level_out <= ~level;
  endtask
endmodule
`default_nettype wire

// >>> tb/test_idm_data_map.sv
// self-checking testbench of the internal data memory map
`timescale 1ns/1ps
`default_nettype none
module test_idm_data_map;
  import idm_pkg::*;
  logic clk;
  logic resetn;
  logic req;
  logic [3:0] op_code;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic wbit;
  logic irq_ack;
  logic irq_level;
  logic done;
  logic [7:0] rdata;
  logic rbit;
  logic xreq;
  logic xwe;
  logic [15:0] xaddr;
  logic [7:0] xwdata;
  logic cint;
  logic cext;
  logic [15:0] caddr;
  logic [1:0] inprog;
  logic [1:0] bank;
  logic [7:0] sp;
  logic last_done;
  int failures = 0;
  int checks_done = 0;

  idm_data_map #(.RAM_BYTES(256), .CODE_ONCHIP(8192)) dut_u (
    .CLK_IN(clk), .RESETN_IN(resetn), .REQ_IN(req), .OP_IN(op_code),
    .ADDR_IN(addr), .WDATA_IN(wdata), .WBIT_IN(wbit),
    .IRQ_ACK_IN(irq_ack), .IRQ_LEVEL_IN(irq_level), .DONE_OUT(done),
    .RDATA_OUT(rdata), .RBIT_OUT(rbit), .XDATA_REQ_OUT(xreq),
    .XDATA_WE_OUT(xwe), .XDATA_ADDR_OUT(xaddr),
    .XDATA_WDATA_OUT(xwdata), .CODE_INT_OUT(cint), .CODE_EXT_OUT(cext),
    .CODE_ADDR_OUT(caddr), .INPROG_OUT(inprog), .BANK_OUT(bank),
    .SP_OUT(sp));

  idm_core_model core_u (
    .clk_in(clk), .done_in(done), .req_out(req), .op_out(op_code),
    .addr_out(addr), .wdata_out(wdata), .wbit_out(wbit),
    .irq_ack_out(irq_ack), .irq_level_out(irq_level));

  // ==========================================================
  // clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    print_verdict();
  end

  // ==========================================================
  // shared tasks
  task automatic check_value(input logic [15:0] seen,
                             input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic op(input idm_op_e o, input logic [15:0] a,
                    input logic [7:0] d, input logic b);
    core_u.issue(o, a, d, b, last_done);
  endtask

  task automatic settle();
    @(posedge clk);
    #1;
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic scen_reset();
    #1;
    check_value({8'h00, sp}, 16'h0007);
    check_value({14'h0, bank}, 16'h0000);
    check_value({14'h0, inprog}, 16'h0000);
  endtask

  task automatic scen_first_push();
    op(OP_PUSH, 16'h0000, 8'h5a, 1'b0);
    check_value({15'h0, last_done}, 16'h0001);
    settle();
    check_value({8'h00, sp}, 16'h0008);
    op(OP_IND_RD, 16'h0008, 8'h00, 1'b0);
    check_value({8'h00, rdata}, 16'h005a);
  endtask

  task automatic scen_upper_split();
    op(OP_DIR_WR, 16'h0080, 8'haa, 1'b0);
    op(OP_IND_WR, 16'h0080, 8'hbb, 1'b0);
    op(OP_DIR_RD, 16'h0080, 8'h00, 1'b0);
    check_value({8'h00, rdata}, 16'h00aa);
    op(OP_IND_RD, 16'h0080, 8'h00, 1'b0);
    check_value({8'h00, rdata}, 16'h00bb);
    op(OP_DIR_WR, 16'h0045, 8'h3c, 1'b0);
    op(OP_IND_RD, 16'h0045, 8'h00, 1'b0);
    check_value({8'h00, rdata}, 16'h003c);
    op(OP_IND_WR, 16'h007f, 8'he1, 1'b0);
    op(OP_DIR_RD, 16'h007f, 8'h00, 1'b0);
    check_value({8'h00, rdata}, 16'h00e1);
  endtask

  task automatic scen_stack_upper();
    op(OP_DIR_WR, {8'h00, SP_ADDR}, 8'h7f, 1'b0);
    op(OP_PUSH, 16'h0000, 8'hc3, 1'b0);
    op(OP_IND_RD, 16'h0080, 8'h00, 1'b0);
    check_value({8'h00, rdata}, 16'h00c3);
    op(OP_DIR_RD, 16'h0080, 8'h00, 1'b0);
    check_value({8'h00, rdata}, 16'h00aa);
    op(OP_POP, 16'h0000, 8'h00, 1'b0);
    check_value({8'h00, rdata}, 16'h00c3);
    settle();
    check_value({8'h00, sp}, 16'h007f);
  endtask

  task automatic scen_back_to_back();
    core_u.issue_pair(OP_PUSH, 16'h0000, 8'h3e, OP_POP, 16'h0000, 8'h00);
    check_value({15'h0, done}, 16'h0001);
    check_value({8'h00, rdata}, 16'h003e);
    settle();
    check_value({8'h00, sp}, 16'h007f);
    core_u.issue_pair(OP_POP, 16'h0000, 8'h00, OP_PUSH, 16'h0000, 8'h44);
    check_value({8'h00, rdata}, 16'h00e1);
    op(OP_IND_RD, 16'h007f, 8'h00, 1'b0);
    check_value({8'h00, rdata}, 16'h0044);
    settle();
    check_value({8'h00, sp}, 16'h007f);
  endtask

  task automatic scen_banks();
    logic [7:0] d;
    for (int b = 0; b < 4; b++)
    begin
      d = 8'h90 + 8'(b);
      op(OP_DIR_WR, {8'h00, PSW_ADDR}, {3'h0, 2'(b), 3'h0}, 1'b0);
      op(OP_REG_WR, 16'(b + 1), d, 1'b0);
      op(OP_IND_RD, 16'(8 * b + b + 1), 8'h00, 1'b0);
      check_value({8'h00, rdata}, {8'h00, d});
      op(OP_REG_RD, 16'(b + 1), 8'h00, 1'b0);
      check_value({8'h00, rdata}, {8'h00, d});
      check_value({14'h0, bank}, 16'(b));
    end
    op(OP_DIR_WR, {8'h00, PSW_ADDR}, 8'h00, 1'b0);
  endtask

  task automatic scen_bits();
    logic [7:0] list [4] = '{8'h00, 8'h0a, 8'h3f, 8'h7f};
    for (int i = 0; i < 4; i++)
    begin
      op(OP_BIT_WR, {8'h00, list[i]}, 8'h00, 1'b1);
      op(OP_DIR_RD, 16'h0020 + 16'(list[i][6:3]), 8'h00, 1'b0);
      check_value({8'h00, rdata}, 16'h1 << list[i][2:0]);
      op(OP_BIT_RD, {8'h00, list[i]}, 8'h00, 1'b0);
      check_value({15'h0, rbit}, 16'h0001);
    end
    op(OP_DIR_WR, 16'h002e, 8'h21, 1'b0);
    op(OP_BIT_RD, 16'h0070, 8'h00, 1'b0);
    check_value({15'h0, rbit}, 16'h0001);
    op(OP_BIT_RD, 16'h0071, 8'h00, 1'b0);
    check_value({15'h0, rbit}, 16'h0000);
  endtask

  task automatic scen_external();
    op(OP_XDATA_WR, 16'h1234, 8'h66, 1'b0);
    check_value({14'h0, xreq, xwe}, 16'h0003);
    check_value(xaddr, 16'h1234);
    check_value({8'h00, xwdata}, 16'h0066);
    op(OP_XDATA_RD, 16'hffff, 8'h00, 1'b0);
    check_value({14'h0, xreq, xwe}, 16'h0002);
    check_value(xaddr, 16'hffff);
    op(OP_IND_RD, 16'h0034, 8'h00, 1'b0);
    check_value({8'h00, rdata}, 16'h0000);
    op(OP_DIR_WR, 16'h0035, 8'h12, 1'b0);
    check_value({15'h0, xreq}, 16'h0000);
  endtask

  task automatic scen_code();
    op(OP_CODE_RD, 16'h1fff, 8'h00, 1'b0);
    check_value({14'h0, cint, cext}, 16'h0002);
    check_value(caddr, 16'h1fff);
    op(OP_CODE_RD, 16'h2000, 8'h00, 1'b0);
    check_value({14'h0, cint, cext}, 16'h0001);
    op(OP_CODE_RD, 16'h0045, 8'h00, 1'b0);
    check_value({8'h00, rdata}, 16'h0000);
    check_value({15'h0, xreq}, 16'h0000);
  endtask

  task automatic scen_iret();
    core_u.ack(1'b0);
    core_u.ack(1'b1);
    settle();
    check_value({14'h0, inprog}, 16'h0003);
    op(OP_IRET, 16'h0000, 8'h00, 1'b0);
    check_value({14'h0, inprog}, 16'h0001);
    op(OP_IRET, 16'h0000, 8'h00, 1'b0);
    check_value({14'h0, inprog}, 16'h0000);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    resetn = 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    scen_reset();
    scen_first_push();
    scen_upper_split();
    scen_stack_upper();
    scen_back_to_back();
    scen_banks();
    scen_bits();
    scen_external();
    scen_code();
    scen_iret();
    print_verdict();
  end
endmodule
`default_nettype wire
